// *** psh_pkg.sv ***
// psh_pkg: constants, register map and types of the programmer start handshake block
// assumes a single 50 MHz core clock; no other file defines these names
package psh_pkg;

    localparam int CLK_HZ        = 50_000_000;
    localparam int MS_PER_SEC    = 1000;
    localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_SEC;
    localparam int START_LOW_MS  = 10;

    // register byte addresses
    localparam logic [7:0] ADDR_DEFAULT = 8'h00;
    localparam logic [7:0] ADDR_OPTION0 = 8'h04;
    localparam logic [7:0] ADDR_OPTION3 = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_CONTROL = 8'h18;

    // setting layout, shared by default, option and control words
    localparam int IMG_LSB = 0;
    localparam int PEN_LSB = 4;
    localparam int GO_BIT  = 8;

    // status layout
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_WAIT_BIT  = 1;
    localparam int ST_LOW_BIT   = 2;
    localparam int ST_LINK_BIT  = 3;
    localparam int ST_RES_LSB   = 4;
    localparam int ST_SRC_LSB   = 8;
    localparam int ST_OPT_LSB   = 12;

    localparam logic [1:0] DEF_IMAGE   = 2'h0;
    localparam logic [3:0] DEF_PORTS   = 4'hf;
    localparam logic [2:0] OPT_DEFAULT = 3'h4;
    localparam int         NUM_SET     = 5;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRC_BUTTON,
        SRC_LINE,
        SRC_HOST,
        SRC_NONE
    } psh_src_e;

    typedef struct packed {
        logic [1:0] image;
        logic [3:0] portEn;
    } psh_setting_s;

endpackage : psh_pkg

// *** psh_ms_tick.sv ***
// psh_ms_tick: one-cycle enable pulse once per millisecond
// assumes core_clk at the package rate; clr restarts the millisecond phase
`timescale 1ns/1ps
module psh_ms_tick #(
    parameter int MS_CYCLES = psh_pkg::MS_CYCLES_DEF
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clr,
    output logic      tick
);
    logic [31:0] cnt_q;

    assign tick = !clr && (cnt_q == 32'(MS_CYCLES - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0;
        end else if (clr || tick) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

endmodule : psh_ms_tick

// *** psh_low_filter.sv ***
// psh_low_filter: fires once when the start line has been low for the full start time
// assumes lineLow already synchronised and tick restarted while the line is high
`timescale 1ns/1ps
module psh_low_filter #(
    parameter int LOW_MS = psh_pkg::START_LOW_MS
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic lineLow,
    input  wire logic tick,
    output logic      fire,
    output logic      armed
);
    logic [7:0] msCnt_q;
    logic       armed_q;

    assign fire  = armed_q && lineLow && tick && (msCnt_q == 8'(LOW_MS - 1));
    assign armed = armed_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            msCnt_q <= 8'h0;
            armed_q <= 1'b0;
        end else begin
            // a high line is the only thing that rearms
            if (!lineLow) begin
                armed_q <= 1'b1;
                msCnt_q <= 8'h0;
            end else if (fire) begin
                armed_q <= 1'b0;
                msCnt_q <= 8'h0;
            end else if (tick && armed_q) begin
                msCnt_q <= msCnt_q + 8'h1;
            end
        end
    end

    AST_FIRE_ONCE: assert property (@(posedge core_clk) disable iff (!rst_n)
        fire |=> !fire && !armed_q)
        else $error("start filter fired twice without rearm");

endmodule : psh_low_filter

// *** psh_start_ctrl.sv ***
// psh_start_ctrl: start/active handshake, setting selection, results and AXI4-Lite registers
// assumes an external programming engine that pulses engineDone with enginePass valid
// assumes the start line pad resolves activeOe high as a pull to ground
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps

module psh_start_ctrl #(
    parameter int MS_CYCLES = psh_pkg::MS_CYCLES_DEF
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // control connector
    input  wire logic        activeIn,
    output logic             activeOut,
    output logic             activeOe,
    input  wire logic        startButton,
    input  wire logic        optionOverrideEnableN,
    input  wire logic        optionChoiceBit0,
    input  wire logic        optionChoiceBit1,
    input  wire logic        hostLinkChoice,
    output logic             linkUseRs485,
    output logic             port1Result,
    output logic             port2Result,
    output logic             port3Result,
    output logic             port4Result,
    output logic [3:0]       lampPass,
    output logic [3:0]       lampFail,
    // programming engine
    output logic             engineStart,
    output logic [1:0]       engineImage,
    output logic [3:0]       enginePortEn,
    input  wire logic        engineDone,
    input  wire logic [3:0]  enginePass,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT_HIGH} psh_state_e;

    function automatic psh_pkg::psh_setting_s unpackSet(input logic [31:0] w);
        unpackSet.image  = w[psh_pkg::IMG_LSB +: 2];
        unpackSet.portEn = w[psh_pkg::PEN_LSB +: 4];
    endfunction : unpackSet

    function automatic logic [31:0] packSet(input psh_pkg::psh_setting_s s);
        packSet = 32'h0;
        packSet[psh_pkg::IMG_LSB +: 2] = s.image;
        packSet[psh_pkg::PEN_LSB +: 4] = s.portEn;
    endfunction : packSet

    // select 11 -> 0 ... 00 -> 3, so the option is the inverted pair
    function automatic logic [1:0] optionOf(input logic b1, input logic b0);
        optionOf = ~{b1, b0};
    endfunction : optionOf

    psh_state_e               state_q;
    psh_pkg::psh_setting_s    setStore_q [psh_pkg::NUM_SET];
    psh_pkg::psh_setting_s    hostSet_q;
    psh_pkg::psh_setting_s    cycleSet_q;
    psh_pkg::psh_src_e        src_q;
    logic [2:0]               optUsed_q;
    logic [3:0]               result_q;
    logic                     resultValid_q;
    logic                     hostGo_q;
    logic                     startPulse_q;
    logic                     link_q;
    logic                     oeLag_q;
    logic                     lineS1_q, lineS2_q, btnS1_q, btnS2_q, btnPrev_q;
    logic                     awHeld_q, wHeld_q, bvalid_q, rvalid_q;
    logic [7:0]               awAddr_q;
    logic [31:0]              wData_q, rdata_q;
    logic [1:0]               bresp_q, rresp_q;

    // first stage flops feed only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lineS1_q  <= 1'b1;
            lineS2_q  <= 1'b1;
            btnS1_q   <= 1'b0;
            btnS2_q   <= 1'b0;
            btnPrev_q <= 1'b0;
        end else begin
            lineS1_q  <= activeIn;
            lineS2_q  <= lineS1_q;
            btnS1_q   <= startButton;
            btnS2_q   <= btnS1_q;
            btnPrev_q <= btnS2_q;
        end
    end

    wire lineLow = !lineS2_q;
    wire msTick;
    wire lineFire;
    wire lineArmed;

    psh_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clr      (!lineLow),
        .tick     (msTick)
    );

    psh_low_filter #(.LOW_MS(psh_pkg::START_LOW_MS)) u_filter (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .lineLow  (lineLow),
        .tick     (msTick),
        .fire     (lineFire),
        .armed    (lineArmed)
    );

    // start decision: the line wins, then the button, then the host
    wire       stIdle     = (state_q == ST_IDLE);
    wire       btnPress   = btnS2_q && !btnPrev_q;
    wire       takeLine   = stIdle && lineFire;
    wire       takeButton = stIdle && !lineFire && btnPress;
    wire       takeHost   = stIdle && !lineFire && !btnPress && hostGo_q;
    wire       takeAny    = takeLine || takeButton || takeHost;
    wire       optActive  = !optionOverrideEnableN;
    wire [1:0] optIdx     = optionOf(optionChoiceBit1, optionChoiceBit0);
    wire [2:0] setIdx     = optActive ? ({1'b0, optIdx} + 3'h1) : 3'h0;
    wire [2:0] optCode    = optActive ? {1'b0, optIdx} : psh_pkg::OPT_DEFAULT;
    // host cycles never look at the stored defaults
    wire psh_pkg::psh_setting_s startSet = takeHost ? hostSet_q : setStore_q[setIdx];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= ST_IDLE;
            cycleSet_q    <= '0;
            src_q         <= psh_pkg::SRC_NONE;
            optUsed_q     <= psh_pkg::OPT_DEFAULT;
            startPulse_q  <= 1'b0;
            result_q      <= 4'h0;
            resultValid_q <= 1'b0;
            link_q        <= 1'b0;
            oeLag_q       <= 1'b0;
        end else begin
            link_q       <= hostLinkChoice;
            oeLag_q      <= (state_q == ST_RUN);
            startPulse_q <= takeAny;
            unique case (state_q)
                ST_IDLE: begin
                    if (takeAny) begin
                        state_q       <= ST_RUN;
                        cycleSet_q    <= startSet;
                        optUsed_q     <= takeHost ? psh_pkg::OPT_DEFAULT : optCode;
                        src_q         <= takeLine ? psh_pkg::SRC_LINE :
                                         takeButton ? psh_pkg::SRC_BUTTON : psh_pkg::SRC_HOST;
                        resultValid_q <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (engineDone) begin
                        state_q       <= ST_WAIT_HIGH;
                        result_q      <= enginePass & cycleSet_q.portEn;
                        resultValid_q <= 1'b1;
                    end
                end
                ST_WAIT_HIGH: begin
                    if (!lineLow) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // one extra cycle of pull-down so results settle before the line can rise
    assign activeOe     = (state_q == ST_RUN) || oeLag_q;
    assign activeOut    = 1'b0;
    assign engineStart  = startPulse_q;
    assign engineImage  = cycleSet_q.image;
    assign enginePortEn = cycleSet_q.portEn;
    assign linkUseRs485 = link_q;
    assign port1Result  = result_q[0];
    assign port2Result  = result_q[1];
    assign port3Result  = result_q[2];
    assign port4Result  = result_q[3];
    assign lampPass     = resultValid_q ? result_q : 4'h0;
    assign lampFail     = resultValid_q ? (cycleSet_q.portEn & ~result_q) : 4'h0;

    // register slave: one write and one read in flight, address and data in any order
    wire       doWrite   = awHeld_q && wHeld_q && !bvalid_q;
    wire       wrSetting = (awAddr_q <= psh_pkg::ADDR_OPTION3) && (awAddr_q[1:0] == 2'h0);
    wire       wrControl = (awAddr_q == psh_pkg::ADDR_CONTROL);
    wire [2:0] wrIdx     = 3'(awAddr_q[7:2]);
    wire       rdTake    = s_axi_arvalid && !rvalid_q;
    wire       rdSetting = (s_axi_araddr <= psh_pkg::ADDR_OPTION3) && (s_axi_araddr[1:0] == 2'h0);
    wire [2:0] rdIdx     = 3'(s_axi_araddr[7:2]);

    logic [31:0] statusWord;
    always_comb begin
        statusWord = 32'h0;
        statusWord[psh_pkg::ST_BUSY_BIT]      = (state_q == ST_RUN);
        statusWord[psh_pkg::ST_WAIT_BIT]      = (state_q == ST_WAIT_HIGH);
        statusWord[psh_pkg::ST_LOW_BIT]       = lineLow;
        statusWord[psh_pkg::ST_LINK_BIT]      = link_q;
        statusWord[psh_pkg::ST_RES_LSB +: 4]  = result_q;
        statusWord[psh_pkg::ST_SRC_LSB +: 2]  = src_q;
        statusWord[psh_pkg::ST_OPT_LSB +: 3]  = optUsed_q;
    end

    wire [31:0] ctrlWord = packSet(hostSet_q);
    wire        rdOk     = rdSetting || (s_axi_araddr == psh_pkg::ADDR_STATUS)
                           || (s_axi_araddr == psh_pkg::ADDR_CONTROL);
    wire [31:0] rdWord   = rdSetting ? packSet(setStore_q[rdIdx]) :
                           (s_axi_araddr == psh_pkg::ADDR_STATUS) ? statusWord :
                           (s_axi_araddr == psh_pkg::ADDR_CONTROL) ? ctrlWord : 32'h0;
    wire [31:0] wrMerged = {23'h0, wData_q[8:0]};

    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready  = !wHeld_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 8'h0;
            wData_q  <= 32'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= psh_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= psh_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (wrSetting || wrControl) ? psh_pkg::RESP_OKAY : psh_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (rdTake) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rdWord;
                rresp_q  <= rdOk ? psh_pkg::RESP_OKAY : psh_pkg::RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // settings storage; fields sit in the low byte, go in bit 8
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < psh_pkg::NUM_SET; i++) begin
                setStore_q[i] <= '{image: psh_pkg::DEF_IMAGE, portEn: psh_pkg::DEF_PORTS};
            end
            hostSet_q <= '{image: psh_pkg::DEF_IMAGE, portEn: psh_pkg::DEF_PORTS};
            hostGo_q  <= 1'b0;
        end else begin
            if (doWrite && wrSetting) begin
                setStore_q[wrIdx] <= unpackSet(wrMerged);
            end
            if (doWrite && wrControl) begin
                hostSet_q <= unpackSet(wrMerged);
            end
            // a go written while busy is dropped, not queued; no status bit records it
            if (doWrite && wrControl && wrMerged[psh_pkg::GO_BIT] && stIdle) begin
                hostGo_q <= 1'b1;
            end else if (takeAny || !stIdle) begin
                hostGo_q <= 1'b0;
            end
        end
    end

    // helper: cycles of continuous low on the synchronised line
    logic [31:0] lowRun_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowRun_q <= 32'h0;
        end else if (!lineLow) begin
            lowRun_q <= 32'h0;
        end else if (lowRun_q != 32'hffffffff) begin
            lowRun_q <= lowRun_q + 32'h1;
        end
    end

    AST_LINE_MIN_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        takeLine |-> lowRun_q >= 32'(psh_pkg::START_LOW_MS * MS_CYCLES - 1))
        else $error("line start accepted before the minimum low time");
    AST_HOLD_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        takeAny |=> activeOe && activeOut == 1'b0 throughout (!engineDone [*1]))
        else $error("line not held low after start");
    AST_NO_REARM: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_q == ST_WAIT_HIGH) && lineLow |=> (state_q == ST_WAIT_HIGH) && !engineStart)
        else $error("new cycle without line returning high");
    AST_BUTTON: assert property (@(posedge core_clk) disable iff (!rst_n)
        takeButton |=> engineStart && activeOe ##1 !engineStart)
        else $error("button press did not start a single cycle");
    AST_PORTS_ONLY: assert property (@(posedge core_clk) disable iff (!rst_n)
        resultValid_q |-> (result_q & ~enginePortEn) == 4'h0)
        else $error("result reported for a disabled port");
    AST_OPTION_MAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (takeLine || takeButton) && optActive |=> optUsed_q == {1'b0, ~$past(optionChoiceBit1),
                                                    ~$past(optionChoiceBit0)})
        else $error("option select mapped wrongly");
    AST_DEFAULT_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
        (takeLine || takeButton) && !optActive |=> enginePortEn == $past(setStore_q[0].portEn))
        else $error("default setting not used");
    AST_RESULT_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(activeOe) |-> resultValid_q && result_q == ($past(enginePass, 2) & enginePortEn))
        else $error("results not valid when the line is released");
    AST_LAMPS: assert property (@(posedge core_clk) disable iff (!rst_n)
        resultValid_q |-> (lampPass | lampFail) == enginePortEn && (lampPass & lampFail) == 4'h0)
        else $error("lamps disagree with results");
    AST_LINK: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 linkUseRs485 == $past(hostLinkChoice))
        else $error("link choice not followed");

    COV_LINE_CYCLE: cover property (@(posedge core_clk) disable iff (!rst_n)
        takeLine ##[1:1000] $fell(activeOe));
    COV_BUTTON_CYCLE: cover property (@(posedge core_clk) disable iff (!rst_n) takeButton);
    COV_HOST_CYCLE: cover property (@(posedge core_clk) disable iff (!rst_n) takeHost);
    COV_OPTION: cover property (@(posedge core_clk) disable iff (!rst_n) takeLine && optActive);

endmodule : psh_start_ctrl

// *** psh_ate_model.sv ***
// psh_ate_model: behavioural tester on the open-drain start/active line
// assumes the line's only pull-up is the device's; tester never drives high
`timescale 1ns/1ps
module psh_ate_model (
    input  wire logic       pullLow,
    input  wire logic       devPullLow,
    input  wire logic [3:0] resultIn,
    output logic            lineLevel,
    output logic [3:0]      resultSeen
);
    // wired-and with pull-up: released line reads high, never sourced
    assign lineLevel = ~(pullLow | devPullLow);
    // result pins only read, sampled at the line's rising edge
    always @(posedge lineLevel) resultSeen <= resultIn;
endmodule : psh_ate_model

// *** test_programmer_start_handshake.sv ***
// test_programmer_start_handshake: self-checking bench for psh_start_ctrl
// assumes MS_CYCLES of 5, so a 10 ms start hold is 50 clocks
`timescale 1ns/1ps
module test_programmer_start_handshake;
    logic core_clk = 1'b0, rst_n = 1'b0, pullLow = 1'b0, startButton = 1'b0;
    logic optionOverrideEnableN = 1'b1, optionChoiceBit0 = 1'b1, optionChoiceBit1 = 1'b1;
    logic hostLinkChoice = 1'b0, engineDone = 1'b0, lineLevel, activeOe, engineStart;
    logic [3:0] enginePass = 4'h0, seen, lampPass, lampFail, enginePortEn;
    wire  [3:0] res;
    logic [1:0] engineImage, s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, linkUseRs485;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int errCount = 0, testsRun = 0, starts = 0;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (engineStart === 1'b1) starts++;
    psh_start_ctrl #(.MS_CYCLES(5)) dut_u (
        .core_clk, .rst_n, .activeIn(lineLevel), .activeOut(), .activeOe, .startButton,
        .optionOverrideEnableN, .optionChoiceBit0, .optionChoiceBit1, .hostLinkChoice,
        .linkUseRs485, .port1Result(res[0]), .port2Result(res[1]), .port3Result(res[2]),
        .port4Result(res[3]), .lampPass, .lampFail, .engineStart, .engineImage,
        .enginePortEn, .engineDone, .enginePass, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    psh_ate_model ate_u (.pullLow, .devPullLow(activeOe), .resultIn(res), .lineLevel,
        .resultSeen(seen));
    task finishTest;
        if (errCount == 0 && testsRun > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finishTest
    task hangStop;
        errCount++;
        finishTest();
    endtask : hangStop
    task check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 50) hangStop();
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask : axiWrite
    task automatic axiRead(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 50) hangStop();
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask : axiRead
    // mode 0 line, 1 button, 2 host go; keepLow holds the line through the cycle
    task automatic runCycle(input int mode, input logic keepLow, input logic [3:0] pass,
                            input logic [5:0] expSet);
        int n;
        int s0;
        s0 = starts;
        if (mode == 2) axiWrite(psh_pkg::ADDR_CONTROL, 32'h131);
        else if (mode == 1) startButton <= 1'b1;
        else pullLow <= 1'b1;
        for (n = 0; n < 300 && engineStart !== 1'b1; n++) @(posedge core_clk);
        if (n == 300) hangStop();
        check(32'({engineImage, enginePortEn}), 32'(expSet));
        startButton <= 1'b0;
        pullLow <= keepLow;
        repeat (4) @(posedge core_clk);
        check(32'({activeOe, lineLevel}), 32'h2);
        engineDone <= 1'b1;
        enginePass <= pass;
        @(posedge core_clk);
        engineDone <= 1'b0;
        // held line: no restart however long it stays low
        if (keepLow) repeat (120) @(posedge core_clk);
        check(starts, s0 + 1);
        pullLow <= 1'b0;
        for (n = 0; n < 20 && lineLevel !== 1'b1; n++) @(posedge core_clk);
        if (n == 20) hangStop();
        check(32'(seen), 32'(pass & expSet[3:0]));
        check(32'({lampPass, lampFail}), 32'({pass & expSet[3:0], ~pass & expSet[3:0]}));
        repeat (8) @(posedge core_clk);
    endtask : runCycle
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge core_clk);
        axiRead(psh_pkg::ADDR_DEFAULT);
        check(32'(resp), 32'(psh_pkg::RESP_OKAY));
        check(rd, 32'h0f0);
        axiRead(8'h40);
        check(32'(resp), 32'(psh_pkg::RESP_SLVERR));
        axiWrite(psh_pkg::ADDR_STATUS, 32'h1);
        check(32'(resp), 32'(psh_pkg::RESP_SLVERR));
        // 8 ms pulse, too short to start
        pullLow <= 1'b1;
        repeat (40) @(posedge core_clk);
        pullLow <= 1'b0;
        repeat (60) @(posedge core_clk);
        check(starts, 0);
        runCycle(0, 1'b0, 4'b0110, 6'h0f);
        runCycle(1, 1'b0, 4'b1001, 6'h0f);
        runCycle(0, 1'b1, 4'b1111, 6'h0f);
        for (int k = 0; k < 4; k++) begin
            axiWrite(psh_pkg::ADDR_OPTION0 + 8'(4 * k), 32'((k + 1) * 16 + k));
            optionOverrideEnableN <= 1'b0;
            {optionChoiceBit1, optionChoiceBit0} <= ~2'(k);
            runCycle(0, 1'b0, 4'b0011, {2'(k), 4'(k + 1)});
        end
        runCycle(2, 1'b0, 4'b1100, 6'h13);
        hostLinkChoice <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(32'(linkUseRs485), 32'h1);
        // status: idle, link rs485, no passes, host source, default option code
        axiRead(psh_pkg::ADDR_STATUS);
        check(rd, 32'h4208);
        finishTest();
    end
endmodule : test_programmer_start_handshake
